/* core/efs_pkg.sv */
package efs_pkg;
    // Reference clock period in nanoseconds.
    localparam int CLK_NS = 4;
    localparam int REF_HZ = 250000000;
    // Serial timing limits, in nanoseconds.
    localparam int T_ST_NS = 30000;
    localparam int T_TOT_NS = 60000;
    localparam int T_LONG_NS = 200000;
    localparam int T_SPD_NS = 250000;
    localparam int T_CTL_NS = 200000;
    // Longest times round down to whole cycles.
    localparam int ST_CYC = T_ST_NS / CLK_NS;
    localparam int TOT_CYC = T_TOT_NS / CLK_NS;
    localparam int LONG_CYC = T_LONG_NS / CLK_NS;
    // Periods are exact multiples of the clock.
    localparam int SPD_CYC = T_SPD_NS / CLK_NS;
    localparam int CTL_CYC = T_CTL_NS / CLK_NS;
    // Bit periods in clock cycles per rate code.
    localparam logic [15:0] PER [8] = '{16'(REF_HZ / 100000),
        16'(REF_HZ / 200000), 16'(REF_HZ / 300000), 16'(REF_HZ / 400000),
        16'(REF_HZ / 500000), 16'(REF_HZ / 1000000), 16'(REF_HZ / 1500000),
        16'(REF_HZ / 2000000)};
    localparam logic [15:0] PER_ASYNC = 16'(REF_HZ / 9600);
    // Register indices.
    localparam logic [3:0] A_RES = 4'h0;
    localparam logic [3:0] A_THERM = 4'h1;
    localparam logic [3:0] A_SUP = 4'h2;
    localparam logic [3:0] A_RATE = 4'h3;
    localparam logic [3:0] A_KIND = 4'h4;
    localparam logic [3:0] A_ROT = 4'h5;
    localparam logic [3:0] A_LINES = 4'h6;
    localparam logic [3:0] A_DIV = 4'h7;
    localparam logic [3:0] A_ALARM = 4'h8;
    localparam logic [3:0] A_STAT = 4'h9;
    localparam logic [3:0] A_CPOS = 4'ha;
    localparam logic [3:0] A_SPD = 4'hb;
    // Values after reset and legal maxima.
    localparam logic [2:0] RATE_RST = 3'h2;
    localparam logic [1:0] ROT_RST = 2'h1;
    localparam logic [15:0] LINES_RST = 16'h1000;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [5:0] RES_MAX = 6'h20;
    localparam logic [3:0] KIND_MAX = 4'hc;
    localparam logic [1:0] SUP_MAX = 2'h2;
    localparam logic [1:0] ROT_MAX = 2'h2;
    localparam logic [15:0] LINES_MAX = 16'hc350;
    // Encoder kind codes.
    localparam logic [3:0] K_SC = 4'h6;
    localparam logic [3:0] K_SC_ASYNC = 4'h7;
    localparam logic [3:0] K_ABS_ONLY = 4'h8;
    localparam logic [3:0] K_SC_ABS = 4'h9;
    localparam logic [3:0] K_SYNC_ONLY = 4'ha;
    localparam logic [3:0] K_SC_SYNC = 4'hb;
    localparam logic [3:0] K_SC_COMM = 4'hc;
    // One third of a turn of electrical angle.
    localparam logic [15:0] ANG_120 = 16'h5556;
    // Status bit positions.
    localparam int S_FAST = 0;
    localparam int S_LONG = 1;
    localparam int S_SUPPLY = 2;
    localparam int S_PHASE = 3;
    localparam int S_UVW = 4;

    // Frame receiver states.
    typedef enum logic [1:0] {
        efs_idle = 2'b01,
        efs_recv = 2'b10
    } efs_state_t;

    // Decoded configuration handed to the feedback path.
    typedef struct packed {
        logic [1:0] incr_mode;
        logic commut;
        logic [15:0] bit_period;
        logic [5:0] eff_res;
        logic whole_pos;
        logic rotary;
        logic [1:0] supply;
        logic therm_en;
        logic lines_used;
        logic vector_only;
        logic abs_pos;
        logic extra_comms;
    } efs_cfg_t;
endpackage : efs_pkg

/* core/efs_core.sv */
// Notes on behaviour
// - rate codes 0..7 give 100k to 2M.
// - async serial kind always runs 9600 baud.
// - fast timing met samples every control interrupt.
// - otherwise sample every 250 us.
// - speed position sampled every 250 us.
// - samples corrected by speed over 250 us.
// - control position per current sample or 200us.
// - resolution 0..32, below one means one.
// - linear async serial always uses 32 bits.
// - rotary selector gives bits per revolution.
// - linear selector gives whole position bits on sincos serial kinds.
// - incremental and plain kinds ignore resolution.
// - supply alarm bit may raise trip six.
// - supply code gives 5, 8, 15 V.
// - kinds 0..5 incremental, range 0..12.
// - commutation inputs cover first 120 degrees.
// - plain sine/cosine is incremental, vector only.
// - sincos and serial positions compared, trip.
// - absolute serial-only kind, no extra comms.
// - lines divided by divider; serial-only ignores.
// - thermistor check bit, off after reset.
// - rotary selector 0 linear, 1-2 rotary.
`timescale 1ns/1ps
`default_nettype none
module efs_core #(
    parameter int ST_CYC = efs_pkg::ST_CYC,
    parameter int TOT_CYC = efs_pkg::TOT_CYC,
    parameter int LONG_CYC = efs_pkg::LONG_CYC,
    parameter int SPD_CYC = efs_pkg::SPD_CYC,
    parameter int CTL_CYC = efs_pkg::CTL_CYC,
    parameter logic [31:0] PH_TOL = 32'h0000_0100
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_enc_clk,
    input wire logic i_enc_dat,
    input wire logic i_enc_frm,
    input wire logic i_ctrl_irq,
    input wire logic i_cur_sample,
    input wire logic i_init,
    input wire logic [15:0] i_elec_ang,
    input wire logic [31:0] i_sincos_pos,
    output logic o_enc_req,
    output efs_pkg::efs_cfg_t o_cfg,
    output logic [31:0] o_ctrl_pos,
    output logic [31:0] o_spd_pos,
    output logic [31:0] o_speed,
    output logic o_fast_mode,
    output logic o_long_err,
    output logic o_supply_trip,
    output logic o_phase_trip,
    output logic o_use_uvw
);
    // Software settings.
    logic [5:0] res_reg;
    logic therm_reg;
    logic [1:0] sup_reg;
    logic [2:0] rate_reg;
    logic [3:0] kind_reg;
    logic [1:0] rot_reg;
    logic [15:0] lines_reg;
    logic [15:0] div_reg;
    logic alarm_reg;
    // Link samplers, two stages each.
    logic [1:0] clk_s_reg;
    logic [1:0] dat_s_reg;
    logic [1:0] frm_s_reg;
    logic clk_d_reg;
    logic frm_d_reg;
    // Frame receiver state.
    efs_pkg::efs_state_t st_reg;
    logic [15:0] t_reg;
    logic [5:0] nbit_reg;
    logic [31:0] sh_reg;
    logic st_ok_reg;
    logic over_reg;
    // Results and sticky flags.
    logic [31:0] pos_reg;
    logic fast_reg;
    logic [15:0] spd_cnt_reg;
    logic [15:0] ctl_cnt_reg;
    logic [15:0] base_reg;
    // Edge and end-of-frame events.
    logic edge_clk;
    logic frm_end;
    logic spd_tick;
    logic ctl_tick;
    logic wr_stat;
    logic [15:0] ang_d;
    logic [31:0] comp;
    logic [31:0] ph_d;
    logic signed [48:0] prod;

    // True for kinds that carry a serial link.
    function automatic logic is_ser(input logic [3:0] k);
        return k >= efs_pkg::K_SC_ASYNC && k <= efs_pkg::K_SC_SYNC;
    endfunction : is_ser

    // True for kinds with only a serial link.
    function automatic logic is_ser_only(input logic [3:0] k);
        return k == efs_pkg::K_ABS_ONLY || k == efs_pkg::K_SYNC_ONLY;
    endfunction : is_ser_only

    // Synchronous-serial kinds carry the supply alarm bit.
    function automatic logic is_sync(input logic [3:0] k);
        return k == efs_pkg::K_SYNC_ONLY || k == efs_pkg::K_SC_SYNC;
    endfunction : is_sync

    // Register writes, each but the alarm bit checked against its legal range.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            res_reg <= 6'h00;
            therm_reg <= 1'b0;
            sup_reg <= 2'h0;
            rate_reg <= efs_pkg::RATE_RST;
            kind_reg <= 4'h0;
            rot_reg <= efs_pkg::ROT_RST;
            lines_reg <= efs_pkg::LINES_RST;
            div_reg <= efs_pkg::DIV_RST;
            alarm_reg <= 1'b0;
        end else if (i_wr) begin
            // A rejected write leaves the old value in place.
            unique case (i_addr)
                efs_pkg::A_RES: if (i_wdata <= 32'(efs_pkg::RES_MAX)) res_reg <= i_wdata[5:0];
                efs_pkg::A_THERM: if (i_wdata[31:1] == 31'h0) therm_reg <= i_wdata[0];
                efs_pkg::A_SUP: if (i_wdata <= 32'(efs_pkg::SUP_MAX)) sup_reg <= i_wdata[1:0];
                efs_pkg::A_RATE: if (i_wdata[31:3] == 29'h0) rate_reg <= i_wdata[2:0];
                efs_pkg::A_KIND: if (i_wdata <= 32'(efs_pkg::KIND_MAX)) kind_reg <= i_wdata[3:0];
                efs_pkg::A_ROT: if (i_wdata <= 32'(efs_pkg::ROT_MAX)) rot_reg <= i_wdata[1:0];
                efs_pkg::A_LINES: if (i_wdata <= 32'(efs_pkg::LINES_MAX)) lines_reg <= i_wdata[15:0];
                // A zero divider would make the line count meaningless.
                efs_pkg::A_DIV: if (i_wdata[31:16] == 16'h0 && i_wdata[15:0] != 16'h0) div_reg <= i_wdata[15:0];
                efs_pkg::A_ALARM: alarm_reg <= i_wdata[0];
                default: ;
            endcase
        end
    end

    // Read data appear in the cycle after the strobe.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                efs_pkg::A_RES: o_rdata <= {26'h0, res_reg};
                efs_pkg::A_THERM: o_rdata <= {31'h0, therm_reg};
                efs_pkg::A_SUP: o_rdata <= {30'h0, sup_reg};
                efs_pkg::A_RATE: o_rdata <= {29'h0, rate_reg};
                efs_pkg::A_KIND: o_rdata <= {28'h0, kind_reg};
                efs_pkg::A_ROT: o_rdata <= {30'h0, rot_reg};
                efs_pkg::A_LINES: o_rdata <= {16'h0, lines_reg};
                efs_pkg::A_DIV: o_rdata <= {16'h0, div_reg};
                efs_pkg::A_ALARM: o_rdata <= {31'h0, alarm_reg};
                efs_pkg::A_STAT: o_rdata <= {27'h0, o_use_uvw, o_phase_trip, o_supply_trip, o_long_err, fast_reg};
                efs_pkg::A_CPOS: o_rdata <= o_ctrl_pos;
                efs_pkg::A_SPD: o_rdata <= o_speed;
                // Unmapped indices read as zero.
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // Decoded settings are registered so the loop sees clean levels.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_cfg <= '0;
        end else begin
            // Quadrature, frequency/direction or forward/reverse decoding.
            o_cfg.incr_mode <= (kind_reg < efs_pkg::K_SC) ? 2'(kind_reg % 4'h3) : 2'h0;
            o_cfg.commut <= (kind_reg >= 4'h3 && kind_reg < efs_pkg::K_SC) || kind_reg == efs_pkg::K_SC_COMM;
            o_cfg.bit_period <= (kind_reg == efs_pkg::K_SC_ASYNC) ? efs_pkg::PER_ASYNC : efs_pkg::PER[rate_reg];
            if (!is_ser(kind_reg))
                o_cfg.eff_res <= 6'h00;
            else if (kind_reg == efs_pkg::K_SC_ASYNC && rot_reg == 2'h0)
                o_cfg.eff_res <= efs_pkg::RES_MAX;
            else
                o_cfg.eff_res <= (res_reg == 6'h00) ? 6'h01 : res_reg;
            // Linear serial kinds with sine/cosine read the setting as whole-position bits.
            o_cfg.whole_pos <= is_ser(kind_reg) && !is_ser_only(kind_reg) && rot_reg == 2'h0;
            o_cfg.rotary <= rot_reg != 2'h0;
            o_cfg.supply <= sup_reg;
            o_cfg.therm_en <= therm_reg;
            o_cfg.lines_used <= !is_ser_only(kind_reg);
            o_cfg.vector_only <= kind_reg == efs_pkg::K_SC;
            o_cfg.abs_pos <= kind_reg > efs_pkg::K_SC;
            o_cfg.extra_comms <= kind_reg == efs_pkg::K_SC_ASYNC || kind_reg == efs_pkg::K_SC_ABS;
        end
    end

    // Link pins pass two flip-flops before any logic looks at them.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            clk_s_reg <= 2'h0;
            dat_s_reg <= 2'h0;
            frm_s_reg <= 2'h0;
            clk_d_reg <= 1'b0;
            frm_d_reg <= 1'b0;
        end else begin
            clk_s_reg <= {clk_s_reg[0], i_enc_clk};
            dat_s_reg <= {dat_s_reg[0], i_enc_dat};
            frm_s_reg <= {frm_s_reg[0], i_enc_frm};
            clk_d_reg <= clk_s_reg[1];
            frm_d_reg <= frm_s_reg[1];
        end
    end

    assign edge_clk = clk_s_reg[1] && !clk_d_reg;
    assign frm_end = st_reg == efs_pkg::efs_recv && !frm_s_reg[1];

    // Frame receiver: shifts bits MSB first and times the message.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            st_reg <= efs_pkg::efs_idle;
            t_reg <= 16'h0000;
            nbit_reg <= 6'h00;
            sh_reg <= 32'h0000_0000;
            st_ok_reg <= 1'b0;
            over_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                efs_pkg::efs_idle: begin
                    if (frm_s_reg[1] && !frm_d_reg && is_ser(kind_reg)) begin
                        st_reg <= efs_pkg::efs_recv;
                        t_reg <= 16'h0000;
                        nbit_reg <= 6'h00;
                        // A short frame must not inherit the upper bits of the last one.
                        sh_reg <= 32'h0000_0000;
                        st_ok_reg <= 1'b0;
                        over_reg <= 1'b0;
                    end
                end
                efs_pkg::efs_recv: begin
                    if (!frm_s_reg[1]) begin
                        st_reg <= efs_pkg::efs_idle;
                    end else begin
                        // The timer saturates at the message limit.
                        if (t_reg < 16'(LONG_CYC)) begin
                            t_reg <= t_reg + 16'h0001;
                        end else begin
                            over_reg <= 1'b1;
                        end
                        if (edge_clk) begin
                            sh_reg <= {sh_reg[30:0], dat_s_reg[1]};
                            if (nbit_reg != 6'h3f) nbit_reg <= nbit_reg + 6'h01;
                            // Single-turn part is in once the resolution is counted.
                            if (nbit_reg + 6'h01 == o_cfg.eff_res && t_reg <= 16'(ST_CYC))
                                st_ok_reg <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Speed correction moves the sample forward to the frame end.
    assign prod = $signed({{17{o_speed[31]}}, o_speed}) * $signed({33'h0, t_reg});
    assign comp = sh_reg + 32'(prod / $signed(49'(SPD_CYC)));
    assign ph_d = (i_sincos_pos > comp) ? i_sincos_pos - comp : comp - i_sincos_pos;

    // Frame results: position and sampling mode.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pos_reg <= 32'h0000_0000;
            fast_reg <= 1'b0;
        end else if (frm_end) begin
            // An over-long message leaves the last good position.
            if (!over_reg) pos_reg <= comp;
            fast_reg <= st_ok_reg && t_reg <= 16'(TOT_CYC);
        end
    end

    // Sticky flags: a new event wins over a software clear.
    assign wr_stat = i_wr && i_addr == efs_pkg::A_STAT;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_long_err <= 1'b0;
            o_supply_trip <= 1'b0;
            o_phase_trip <= 1'b0;
        end else begin
            if (frm_end && over_reg)
                o_long_err <= 1'b1;
            else if (wr_stat && i_wdata[efs_pkg::S_LONG])
                o_long_err <= 1'b0;
            if (frm_end && alarm_reg && is_sync(kind_reg) && !sh_reg[0])
                o_supply_trip <= 1'b1;
            else if (wr_stat && i_wdata[efs_pkg::S_SUPPLY])
                o_supply_trip <= 1'b0;
            if (frm_end && is_ser(kind_reg) && !is_ser_only(kind_reg) && ph_d > PH_TOL)
                o_phase_trip <= 1'b1;
            else if (wr_stat && i_wdata[efs_pkg::S_PHASE])
                o_phase_trip <= 1'b0;
        end
    end

    // Free-running 250 us and 200 us period counters.
    assign spd_tick = spd_cnt_reg == 16'(SPD_CYC - 1);
    assign ctl_tick = ctl_cnt_reg == 16'(CTL_CYC - 1);
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            spd_cnt_reg <= 16'h0000;
            ctl_cnt_reg <= 16'h0000;
        end else begin
            spd_cnt_reg <= spd_tick ? 16'h0000 : spd_cnt_reg + 16'h0001;
            ctl_cnt_reg <= ctl_tick ? 16'h0000 : ctl_cnt_reg + 16'h0001;
        end
    end

    // Encoder read requests: per interrupt when fast, else per 250 us.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_enc_req <= 1'b0;
        end else begin
            o_enc_req <= is_ser(kind_reg) && (fast_reg ? i_ctrl_irq : spd_tick);
        end
    end

    // Speed position and the speed over the last 250 us.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_spd_pos <= 32'h0000_0000;
            o_speed <= 32'h0000_0000;
        end else if (spd_tick) begin
            o_spd_pos <= pos_reg;
            o_speed <= pos_reg - o_spd_pos;
        end
    end

    // Reference-frame control position.
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_ctrl_pos <= 32'h0000_0000;
        end else if (fast_reg ? i_cur_sample : ctl_tick) begin
            o_ctrl_pos <= pos_reg;
        end
    end

    // Commutation inputs steer position until 120 degrees have passed.
    assign ang_d = i_elec_ang - base_reg;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_use_uvw <= 1'b1;
            base_reg <= 16'h0000;
        end else if (i_init) begin
            o_use_uvw <= 1'b1;
            base_reg <= i_elec_ang;
        end else if (ang_d >= efs_pkg::ANG_120 && (-ang_d) >= efs_pkg::ANG_120) begin
            o_use_uvw <= 1'b0;
        end
    end

    assign o_fast_mode = fast_reg;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_rate_code: assert property (kind_reg != efs_pkg::K_SC_ASYNC && $stable(kind_reg) && $stable(rate_reg)
        |=> o_cfg.bit_period == efs_pkg::PER[$past(rate_reg)]) else $error("bit period wrong");
    a_async_rate: assert property (kind_reg == efs_pkg::K_SC_ASYNC
        |=> o_cfg.bit_period == efs_pkg::PER_ASYNC) else $error("async rate not fixed");
    a_fast_req: assert property (fast_reg && i_ctrl_irq && is_ser(kind_reg) |=> o_enc_req)
        else $error("fast request missed");
    a_slow_req: assert property (!fast_reg && !spd_tick |=> !o_enc_req)
        else $error("slow request off period");
    a_spd_period: assert property (spd_tick |=> !spd_tick [*8]) else $error("speed tick too soon");
    a_long_flag: assert property (frm_end && over_reg |=> o_long_err && pos_reg == $past(pos_reg))
        else $error("long message not flagged");
    a_ctrl_slow: assert property (!fast_reg && !ctl_tick |=> $stable(o_ctrl_pos))
        else $error("control position moved early");
    a_res_min: assert property (is_ser(kind_reg) && $stable(kind_reg) |=> o_cfg.eff_res != 6'h00)
        else $error("resolution below one");
    a_res_ignored: assert property (!is_ser(kind_reg) |=> o_cfg.eff_res == 6'h00)
        else $error("resolution not ignored");
    a_reject: assert property (i_wr && i_addr == efs_pkg::A_KIND && i_wdata > 32'(efs_pkg::KIND_MAX)
        |=> $stable(kind_reg)) else $error("bad kind accepted");
    a_trip_six: assert property (frm_end && alarm_reg && is_sync(kind_reg) && !sh_reg[0]
        |=> o_supply_trip) else $error("supply trip missed");

    c_fast: cover property (frm_end && st_ok_reg ##1 fast_reg);
    c_slow_req: cover property (!fast_reg && o_enc_req);
    c_long: cover property ($rose(o_long_err));
    c_uvw_done: cover property ($fell(o_use_uvw));
endmodule : efs_core
`default_nettype wire

/* dv/efs_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Position encoder on the far side of the serial link.
module efs_enc_model (
    output var logic o_clk,
    output var logic o_dat,
    output var logic o_frm
);
    // The link clock stands still low between frames.
    initial begin
        o_clk = 1'b0;
        o_dat = 1'b1;
        o_frm = 1'b0;
    end
    // Sends one frame MSB first at 125 ns a bit; bits above 32 carry filler.
    // Short frames answer promptly, long ones answer slowly; only the bench picks an overlong one.
    task automatic send(input logic [31:0] w, input int n);
        // A quarter nanosecond offset keeps every pin change off the reference clock edge.
        #0.25;
        o_frm = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            o_dat = (i < 32) ? w[i] : i[0];
            #62.5 o_clk = 1'b1;
            #62.5 o_clk = 1'b0;
        end
        o_frm = 1'b0;
        // A released data line must not keep looking like the last bit.
        o_dat = ~o_dat;
    endtask : send
endmodule : efs_enc_model
`default_nettype wire

/* dv/efs_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module efs_core_tb;
    logic clk, rstn, wr, rd, irq, cur, init, ec, ed, ef, req, fast, lerr, strip, ptrip, uvw;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, sc_pos, v, spos;
    logic [15:0] ang;
    efs_pkg::efs_cfg_t cfg;
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 32'hc11b;
    int cyc = 0;
    int n, r;
    // Short counts keep the run brief; the speed tick period below matches them.
    localparam int SPD = 3000;
    localparam logic [31:0] RST [9] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h1, 32'h1000, 32'h1, 32'h0};
    efs_core #(.ST_CYC(600), .TOT_CYC(1200), .LONG_CYC(2500), .SPD_CYC(SPD), .CTL_CYC(2400)) dut (
        .i_ref_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_enc_clk(ec), .i_enc_dat(ed), .i_enc_frm(ef), .i_ctrl_irq(irq),
        .i_cur_sample(cur), .i_init(init), .i_elec_ang(ang), .i_sincos_pos(sc_pos), .o_enc_req(req),
        .o_cfg(cfg), .o_ctrl_pos(), .o_spd_pos(spos), .o_speed(), .o_fast_mode(fast), .o_long_err(lerr),
        .o_supply_trip(strip), .o_phase_trip(ptrip), .o_use_uvw(uvw));
    efs_enc_model enc (.o_clk(ec), .o_dat(ed), .o_frm(ef));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Current samples arrive at random so the control position path keeps moving.
    always @(posedge clk) begin
        cur <= ($random(seed) & 15) == 0;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    // Selects a kind and resolution, sends one frame and lets the results settle.
    task automatic frame(input logic [3:0] k, input logic [5:0] res, input logic [31:0] w, input int nb);
        wreg(efs_pkg::A_KIND, 32'(k));
        wreg(efs_pkg::A_RES, 32'(res));
        enc.send(w, nb);
        repeat (8) @(posedge clk);
        #1;
    endtask : frame
    // Width the receiver should use for a serial kind.
    function automatic logic [5:0] eff(input logic [3:0] k, input logic [1:0] rot, input int res);
        if (k == efs_pkg::K_SC_ASYNC && rot == 2'h0) return 6'h20;
        return (res < 1) ? 6'h01 : 6'(res);
    endfunction : eff
    initial begin
        {wr, rd, irq, init} = 4'h0;
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        ang = 16'h0;
        sc_pos = 32'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rreg(4'(i), v);
            chk("reset value", RST[i], v);
        end
        rreg(4'hc, v);
        chk("unmapped", 32'h0, v);
        chk("uvw after reset", 32'h1, 32'(uvw));
        wreg(efs_pkg::A_KIND, 32'(efs_pkg::K_SYNC_ONLY));
        for (int c = 0; c < 9; c++) begin
            wreg(efs_pkg::A_RATE, 32'(c));
            chk("bit period", 32'(efs_pkg::PER[(c > 7) ? 7 : c]), 32'(cfg.bit_period));
        end
        wreg(efs_pkg::A_KIND, 32'(efs_pkg::K_SC_ASYNC));
        chk("async period", 32'(efs_pkg::PER_ASYNC), 32'(cfg.bit_period));
        for (int c = 0; c < 4; c++) begin
            wreg(efs_pkg::A_SUP, 32'(c));
            chk("supply", 32'((c > 2) ? 2 : c), 32'(cfg.supply));
        end
        wreg(efs_pkg::A_THERM, 32'h1);
        chk("therm", 32'h1, 32'(cfg.therm_en));
        wreg(efs_pkg::A_THERM, 32'h2);
        chk("therm kept", 32'h1, 32'(cfg.therm_en));
        for (int k = 0; k < 13; k++) begin
            wreg(efs_pkg::A_KIND, 32'(k));
            if (k < 6) chk("incr mode", 32'(k % 3), 32'(cfg.incr_mode));
            if (k < 6) chk("commut", 32'(k >= 3), 32'(cfg.commut));
            if (k == 6) chk("vector only", 32'h1, 32'(cfg.vector_only));
            if (k == 8) chk("abs no comms", 32'h2, {cfg.abs_pos, cfg.extra_comms});
            chk("lines used", 32'(k != 8 && k != 10), 32'(cfg.lines_used));
        end
        wreg(efs_pkg::A_KIND, 32'hd);
        rreg(efs_pkg::A_KIND, v);
        chk("kind kept", 32'hc, v);
        r = 0;
        repeat (8) begin
            n = $random(seed) & 63;
            wreg(efs_pkg::A_RES, 32'(n));
            if (n <= 32) r = n;
            rreg(efs_pkg::A_RES, v);
            chk("res", 32'(r), v);
        end
        wreg(efs_pkg::A_KIND, 32'(efs_pkg::K_SYNC_ONLY));
        wreg(efs_pkg::A_RES, 32'h0);
        chk("res floor", 32'(eff(efs_pkg::K_SYNC_ONLY, 2'h1, 0)), 32'(cfg.eff_res));
        wreg(efs_pkg::A_KIND, 32'(efs_pkg::K_SC_ASYNC));
        wreg(efs_pkg::A_ROT, 32'h0);
        chk("async linear", 32'(eff(efs_pkg::K_SC_ASYNC, 2'h0, 0)), 32'(cfg.eff_res));
        wreg(efs_pkg::A_KIND, 32'(efs_pkg::K_SC_ABS));
        wreg(efs_pkg::A_RES, 32'h14);
        chk("linear res", 32'h51, {cfg.eff_res, cfg.rotary, cfg.whole_pos});
        wreg(efs_pkg::A_ROT, 32'h2);
        wreg(efs_pkg::A_RES, 32'hd);
        chk("rotary res", 32'h36, {cfg.eff_res, cfg.rotary, cfg.whole_pos});
        wreg(efs_pkg::A_LINES, 32'hc351);
        wreg(efs_pkg::A_DIV, 32'h0);
        rreg(efs_pkg::A_LINES, v);
        chk("lines kept", 32'h1000, v);
        rreg(efs_pkg::A_DIV, v);
        chk("divider kept", 32'h1, v);
        frame(efs_pkg::K_SYNC_ONLY, 6'h8, 32'h0000_a5a5, 16);
        chk("fast", 32'h1, 32'(fast));
        @(posedge clk) irq <= 1'b1;
        @(posedge clk) irq <= 1'b0;
        #1 chk("fast request", 32'h1, 32'(req));
        wreg(efs_pkg::A_ALARM, 32'h1);
        frame(efs_pkg::K_SYNC_ONLY, 6'h8, 32'h0000_1234, 16);
        chk("supply trip", 32'h1, 32'(strip));
        wreg(efs_pkg::A_STAT, 32'h4);
        rreg(efs_pkg::A_STAT, v);
        chk("status clear", 32'h0, 32'(v[2]));
        wreg(efs_pkg::A_ALARM, 32'h0);
        frame(efs_pkg::K_SYNC_ONLY, 6'h18, 32'h0123_4567, 32);
        chk("slow", 32'h0, 32'(fast));
        n = 0;
        repeat (2 * SPD) begin
            @(posedge clk);
            #1 n += int'(req);
        end
        chk("slow requests", 32'h2, 32'(n));
        frame(efs_pkg::K_SYNC_ONLY, 6'h18, 32'h0123_4567, 90);
        chk("long error", 32'h1, 32'(lerr));
        wreg(efs_pkg::A_ROT, 32'h1);
        sc_pos <= 32'h8000_0000;
        frame(efs_pkg::K_SC_SYNC, 6'h8, 32'h0000_0055, 16);
        chk("phase trip", 32'h1, 32'(ptrip));
        // Speed has been zero since the second speed tick after the slow frame, so no correction applies.
        repeat (2 * SPD) @(posedge clk);
        #1 chk("speed position", 32'h55, spos);
        rreg(efs_pkg::A_CPOS, v);
        chk("control position", 32'h55, v);
        rreg(efs_pkg::A_SPD, v);
        chk("speed", 32'h0, v);
        ang <= 16'h5000;
        repeat (6) @(posedge clk);
        #1 chk("uvw short", 32'h1, 32'(uvw));
        ang <= efs_pkg::ANG_120;
        repeat (6) @(posedge clk);
        #1 chk("uvw done", 32'h0, 32'(uvw));
        @(posedge clk) init <= 1'b1;
        @(posedge clk) init <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk("uvw init", 32'h1, 32'(uvw));
        test_done();
    end
endmodule : efs_core_tb
`default_nettype wire
